// ---- pbl_power_latch.sv ----
`timescale 1ns/10ps

module pbl_power_latch
  import pbl_pkg::*;
#(
  parameter logic [CNT_W-1:0] DebounceCyc = CNT_W'(DEBOUNCE_CYC),
  parameter logic [CNT_W-1:0] ShutdownCyc = CNT_W'(SHUTDOWN_CYC),
  parameter logic [CNT_W-1:0] PulseCyc    = CNT_W'(PULSE_CYC),
  parameter logic [CNT_W-1:0] LongCyc     = CNT_W'(LONG_CYC),
  parameter logic [CNT_W-1:0] LockoutCyc  = CNT_W'(LOCKOUT_CYC),
  parameter logic [REL_W-1:0] GlitchCyc   = REL_W'(GLITCH_CYC),
  parameter logic             ShutdownEn  = 1'b1
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // pushbutton, low while closed
  input  wire logic button_n,
  // host clear, low to drop the latch
  input  wire logic latch_clear_n,
  // power latch, push-pull
  output logic      latchOut,
  // interrupt pin, open drain
  output logic      intOut,
  output logic      intOe
);

  // press tracking state
  pbl_state_e       state_q, state_d;
  logic [CNT_W-1:0] hold_q, hold_d;     // cycles since closure began
  logic [REL_W-1:0] rel_q, rel_d;       // consecutive open cycles
  // interrupt one-shot and clear lockout
  logic [CNT_W-1:0] pulse_q, pulse_d;   // remaining pulse cycles
  logic [CNT_W-1:0] lock_q, lock_d;     // remaining lockout cycles
  logic             armed_q, armed_d;   // clear input honoured
  // clear synchroniser
  logic             clrMeta_q, clrSync_q;
  // latch
  logic             latch_q, latch_d;
  logic             asyncClr;
  // events
  logic             pressed, released, accept, shutdown;
  pbl_pulse_s       pulseReq;

  // an open switch reads high via the pin pull-up, so low means closed
  assign pressed  = ~button_n;
  // an open run only ends a closure once it outlasts the glitch filter
  assign released = button_n && (rel_q == GlitchCyc - REL_ONE);

  // press tracking: debounce, hold and long-hold phases
  always_comb begin
    state_d  = state_q;
    hold_d   = hold_q;
    rel_d    = pressed ? REL_ZERO : rel_q + REL_ONE;
    accept   = 1'b0;
    shutdown = 1'b0;
    unique case (state_q)
      PBL_IDLE: begin
        rel_d  = REL_ZERO;
        hold_d = CNT_ZERO;
        if (pressed) begin
          state_d = PBL_DEBNC;
          hold_d  = CNT_ONE;
        end
      end
      PBL_DEBNC: begin
        hold_d = hold_q + CNT_ONE;
        if (released) begin
          state_d = PBL_IDLE;
        end else if (hold_q >= DebounceCyc - CNT_ONE && pressed) begin
          accept  = 1'b1;
          state_d = PBL_HELD;
        end
      end
      PBL_HELD: begin
        hold_d = hold_q + CNT_ONE;
        if (released) begin
          state_d = PBL_IDLE;
        end else if (hold_q >= ShutdownCyc - CNT_ONE) begin
          shutdown = 1'b1;
          state_d  = PBL_LONG;
        end
      end
      PBL_LONG: begin
        // counting stops here; only a real release re-arms a new press
        hold_d = hold_q;
        if (released) begin
          state_d = PBL_IDLE;
        end
      end
      default: begin
        state_d = PBL_IDLE;
      end
    endcase
  end

  // press tracking registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= PBL_IDLE;
      hold_q  <= CNT_ZERO;
      rel_q   <= REL_ZERO;
    end else begin
      state_q <= state_d;
      hold_q  <= hold_d;
      rel_q   <= rel_d;
    end
  end

  // one-shot requests: normal on accept, extended at shutdown
  assign pulseReq.fire     = accept | shutdown;
  assign pulseReq.extended = shutdown;

  // interrupt one-shot and clear lockout
  always_comb begin
    pulse_d = (pulse_q != CNT_ZERO) ? pulse_q - CNT_ONE : CNT_ZERO;
    if (pulseReq.fire) begin
      // extended request restarts the count rather than adding to it
      pulse_d = pulseReq.extended ? LongCyc : PulseCyc;
    end
    lock_d = (lock_q != CNT_ZERO) ? lock_q - CNT_ONE : CNT_ZERO;
    if (accept) begin
      lock_d = LockoutCyc;
    end
    // clear is honoured only with the latch on and lockout run out
    armed_d = latch_d && (lock_d == CNT_ZERO);
  end

  // one-shot and lockout registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pulse_q <= CNT_ZERO;
      lock_q  <= CNT_ZERO;
      armed_q <= 1'b0;
    end else begin
      pulse_q <= pulse_d;
      lock_q  <= lock_d;
      armed_q <= armed_d;
    end
  end

  // two-stage synchroniser for the clear input
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      clrMeta_q <= 1'b1;
      clrSync_q <= 1'b1;
    end else begin
      clrMeta_q <= latch_clear_n;
      clrSync_q <= clrMeta_q;
    end
  end

  // direct clear path; gated by a flop so lockout still applies,
  // giving a glitch-free gate with no arming delay, as armed_d is built from next-state values
  assign asyncClr = ~latch_clear_n & armed_q;

  // latch next value: clear beats set, shutdown only in one variant
  always_comb begin
    latch_d = latch_q;
    if (accept) begin
      latch_d = 1'b1;
    end
    if (shutdown && ShutdownEn) begin
      latch_d = 1'b0;
    end
    if (!clrSync_q && armed_q) begin
      latch_d = 1'b0;
    end
  end

  // latch register with the asynchronous clear
  always_ff @(posedge clk or posedge asyncClr) begin
    if (asyncClr) begin
      latch_q <= 1'b0;
    end else if (sys_rst) begin
      latch_q <= 1'b0;
    end else begin
      latch_q <= latch_d;
    end
  end

  // pins: latch driven both ways, interrupt only ever pulls low
  assign latchOut = latch_q;
  assign intOut   = 1'b0;
  assign intOe    = (pulse_q != CNT_ZERO);

  // helper: length of the current interrupt pulse
  logic [CNT_W-1:0] width_q;
  always_ff @(posedge clk) begin
    if (sys_rst || !intOe) begin
      width_q <= CNT_ZERO;
    end else begin
      width_q <= width_q + CNT_ONE;
    end
  end

  accept_set_a: assert property (@(posedge clk) disable iff (sys_rst)
    accept && !(!clrSync_q && armed_q) |=> latch_q && intOe)
    else $error("accepted press did not set latch and interrupt");

  pulse_len_a: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(intOe) |-> ($past(width_q) == PulseCyc - CNT_ONE ||
                      $past(width_q) == LongCyc - CNT_ONE))
    else $error("interrupt pulse has wrong length");

  short_pulse_a: assert property (@(posedge clk) disable iff (sys_rst)
    accept |=> pulse_q == PulseCyc)
    else $error("normal pulse not loaded on accept");

  long_pulse_a: assert property (@(posedge clk) disable iff (sys_rst)
    shutdown |=> intOe && pulse_q == LongCyc)
    else $error("extended pulse not started at shutdown");

  shut_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
    shutdown && ShutdownEn |=> !latch_q)
    else $error("long hold did not clear latch");

  shut_keep_a: assert property (@(posedge clk) disable iff (sys_rst)
    shutdown && !ShutdownEn && latch_q && clrSync_q |=> latch_q)
    else $error("long hold dropped latch in keep variant");

  int_drive_a: assert property (@(posedge clk) disable iff (sys_rst)
    intOe |-> !intOut)
    else $error("interrupt driven high");

  clear_lockout_a: assert property (@(posedge clk) disable iff (sys_rst)
    accept |=> !armed_q [*8])
    else $error("clear armed during lockout");

  // the direct path usually wins, so watch the raw pin as well as the
  // synchronised copy, or the check would never see a clear
  clear_on_a: assert property (@(posedge clk) disable iff (sys_rst)
    armed_q && !(latch_clear_n && clrSync_q) && !accept |=> !latch_q)
    else $error("armed clear did not drop latch");

  no_retrig_a: assert property (@(posedge clk) disable iff (sys_rst)
    state_q == PBL_LONG |-> !pulseReq.fire)
    else $error("interrupt retriggered during long hold");

  long_quiet_a: assert property (@(posedge clk) disable iff (sys_rst)
    state_q == PBL_LONG && !intOe |=> !intOe)
    else $error("interrupt reasserted after long pulse ended");

  glitch_keep_a: assert property (@(posedge clk) disable iff (sys_rst)
    state_q == PBL_DEBNC && button_n && rel_q < GlitchCyc - REL_ONE
      |=> state_q != PBL_IDLE)
    else $error("short open glitch restarted debounce");

endmodule

// ---- pbl_pkg.sv ----
package pbl_pkg;

  // timing clock rate
  localparam int unsigned CLK_KHZ = 20000;
  localparam int unsigned CLK_MHZ = 20;

  // counter width, wide enough for a 16 s hold at 20 MHz
  localparam int unsigned CNT_W = 29;
  localparam int unsigned REL_W = 14;

  // documented times in their own units
  localparam int unsigned DEBOUNCE_TIME_MS = 50;
  localparam int unsigned SHUTDOWN_TIME_MS = 8000;
  localparam int unsigned PULSE_TIME_MS    = 32;
  localparam int unsigned LONG_PULSE_MS    = 4 * PULSE_TIME_MS;
  localparam int unsigned LOCKOUT_MS       = 2 * PULSE_TIME_MS;
  localparam int unsigned GLITCH_US        = 600;

  // derived cycle counts (all exact at 20 MHz)
  localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_TIME_MS * CLK_KHZ;
  localparam int unsigned SHUTDOWN_CYC = SHUTDOWN_TIME_MS * CLK_KHZ;
  localparam int unsigned PULSE_CYC    = PULSE_TIME_MS * CLK_KHZ;
  localparam int unsigned LONG_CYC     = LONG_PULSE_MS * CLK_KHZ;
  localparam int unsigned LOCKOUT_CYC  = LOCKOUT_MS * CLK_KHZ;
  localparam int unsigned GLITCH_CYC   = GLITCH_US * CLK_MHZ;

  // press tracking states, one-hot
  typedef enum logic [3:0] {
    PBL_IDLE  = 4'h1,
    PBL_DEBNC = 4'h2,
    PBL_HELD  = 4'h4,
    PBL_LONG  = 4'h8
  } pbl_state_e;

  // request to the interrupt one-shot
  typedef struct packed {
    logic fire;
    logic extended;
  } pbl_pulse_s;

  localparam logic [CNT_W-1:0] CNT_ZERO = '0;
  localparam logic [CNT_W-1:0] CNT_ONE  = 29'h0000001;
  localparam logic [REL_W-1:0] REL_ZERO = '0;
  localparam logic [REL_W-1:0] REL_ONE  = 14'h0001;

endpackage

// ---- pbl_button_host.sv ----
`timescale 1ns/10ps

// switch and host as seen from the pins, with pull-ups on open lines
module pbl_button_host (
  // bench commands
  input  wire logic pressReq,
  input  wire logic clearReq,
  // interrupt pin drivers of the device
  input  wire logic intOut,
  input  wire logic intOe,
  // resolved pin levels
  output logic      button_n,
  output logic      latch_clear_n,
  output logic      intPin
);
  // an open switch floats up, only a closure pulls low
  assign button_n      = pressReq ? 1'b0 : 1'b1;
  // host sinks its clear line, else the pull-up wins
  assign latch_clear_n = clearReq ? 1'b0 : 1'b1;
  // wired pin: a released driver leaves the pull-up level
  assign intPin        = intOe ? intOut : 1'b1;
endmodule

// ---- tb_top.sv ----
`timescale 1ns/10ps

module tb_top;
  // one ordinary press and what both builds should show after it
  typedef struct packed {
    logic [8:0] hold; // closed cycles
    logic       expA; // latch, shutdown build
    logic       expB; // latch, keep-on build
    logic [7:0] ints; // interrupt-low cycles
  } pbl_row_s;
  // short, valid, one under and exactly the debounce time,
  // just past shutdown, held past the long pulse
  localparam pbl_row_s ROWS [6] = '{
    '{9'h00f, 1'b0, 1'b0, 8'h00}, '{9'h019, 1'b1, 1'b1, 8'h10},
    '{9'h013, 1'b0, 1'b0, 8'h00}, '{9'h014, 1'b1, 1'b1, 8'h10},
    '{9'h0dc, 1'b0, 1'b1, 8'h50}, '{9'h12c, 1'b0, 1'b1, 8'h50}};
  // shortened counts keep the run brief; lockout is twice the pulse
  localparam logic [28:0] DEB_CYC  = 29'h14;
  localparam logic [28:0] SHUT_CYC = 29'hc8;
  localparam logic [28:0] INT_CYC  = 29'h10;
  localparam logic [28:0] LONG_CYC = 29'h40;
  localparam logic [28:0] LOCK_CYC = 29'h20;
  localparam logic [13:0] GLT_CYC  = 14'h4;
  logic clk, sys_rst, pressReq, clearReq, button_n, latch_clear_n;
  logic latA, intOutA, intOeA, intPinA;
  logic latB, intOutB, intOeB, intPinB;
  int   err_count, samples_checked, cyc, intCntA, intCntB;

  // far side: switch, host and the pulled-up interrupt pins
  pbl_button_host u_host (.pressReq(pressReq), .clearReq(clearReq),
    .intOut(intOutA), .intOe(intOeA), .button_n(button_n),
    .latch_clear_n(latch_clear_n), .intPin(intPinA));
  pbl_button_host u_host_b (.pressReq(pressReq), .clearReq(clearReq),
    .intOut(intOutB), .intOe(intOeB), .button_n(),
    .latch_clear_n(), .intPin(intPinB));
  // both builds share the inputs
  pbl_power_latch #(.DebounceCyc(DEB_CYC), .ShutdownCyc(SHUT_CYC),
    .PulseCyc(INT_CYC), .LongCyc(LONG_CYC), .LockoutCyc(LOCK_CYC),
    .GlitchCyc(GLT_CYC), .ShutdownEn(1'b1)) u_dut (.clk(clk),
    .sys_rst(sys_rst), .button_n(button_n), .latch_clear_n(latch_clear_n),
    .latchOut(latA), .intOut(intOutA), .intOe(intOeA));
  pbl_power_latch #(.DebounceCyc(DEB_CYC), .ShutdownCyc(SHUT_CYC),
    .PulseCyc(INT_CYC), .LongCyc(LONG_CYC), .LockoutCyc(LOCK_CYC),
    .GlitchCyc(GLT_CYC), .ShutdownEn(1'b0)) u_dut_b (.clk(clk),
    .sys_rst(sys_rst), .button_n(button_n), .latch_clear_n(latch_clear_n),
    .latchOut(latB), .intOut(intOutB), .intOe(intOeB));

  // 50 ns clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // count pin-low cycles and cut a hang short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (intPinA === 1'b0) intCntA <= intCntA + 1;
    if (intPinB === 1'b0) intCntB <= intCntB + 1;
    if (cyc == 8000) begin
      err_count++;
      end_of_test();
    end
  end

  task automatic chk(input string what, input logic [7:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s exp %h got %h", what, exp, got);
    end
  endtask

  // close the switch for n cycles; pin counters restart with it
  task automatic press(input int n);
    intCntA  <= 0;
    intCntB  <= 0;
    pressReq <= 1'b1;
    repeat (n) @(posedge clk);
    pressReq <= 1'b0;
  endtask

  // host clear of three cycles after a wait of pre cycles
  task automatic clr(input int pre);
    repeat (pre) @(posedge clk);
    clearReq <= 1'b1;
    repeat (3) @(posedge clk);
    clearReq <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  task automatic end_of_test();
    $display("errors %0d checks %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    {sys_rst, pressReq, clearReq} = 3'b100;
    {err_count, samples_checked, cyc, intCntA, intCntB} = '0;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    chk("latch after reset", 8'h00, 8'(latA));
    foreach (ROWS[i]) begin
      press(ROWS[i].hold);
      repeat (120) @(posedge clk);
      chk("latch A", 8'(ROWS[i].expA), 8'(latA));
      chk("latch B", 8'(ROWS[i].expB), 8'(latB));
      chk("int A", ROWS[i].ints, 8'(intCntA));
      chk("int B", ROWS[i].ints, 8'(intCntB));
      clr(40);
    end
    // a short bounce open keeps the debounce running
    press(10);
    repeat (2) @(posedge clk);
    press(15);
    repeat (120) @(posedge clk);
    chk("bounce latch", 8'h01, 8'(latA));
    chk("bounce int", 8'h10, 8'(intCntA));
    clr(40);
    // a long open restarts the debounce
    press(12);
    repeat (10) @(posedge clk);
    press(12);
    repeat (60) @(posedge clk);
    chk("restart latch", 8'h00, 8'(latA));
    // clear inside the lockout after set is ignored, later it works
    press(25);
    clr(0);
    chk("lockout latch", 8'h01, 8'(latA));
    clr(40);
    chk("clear latch", 8'h00, 8'(latA));
    clr(0);
    chk("clear when off", 8'h00, 8'(latA));
    // reset drops a set latch
    press(25);
    repeat (5) @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    chk("reset latch", 8'h00, 8'(latB));
    chk("reset latch A", 8'h00, 8'(latA));
    end_of_test();
  end
endmodule
